// ===== core/asi_regs.svh
// Register map, field positions, reset values and timing counts.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef ASI_REGS_SVH
`define ASI_REGS_SVH

// ************************************************
// Register byte offsets
// ************************************************
`define ASI_OFF_CTRL 8'h00
`define ASI_OFF_IN_POINTS 8'h04
`define ASI_OFF_OUT_POINTS 8'h08
`define ASI_OFF_STATUS 8'h0C
`define ASI_OFF_MASK 8'h10
`define ASI_OFF_FLAGS 8'h14
`define ASI_OFF_INFO 8'h18

// ************************************************
// Fields and reset values
// ************************************************
`define ASI_CTRL_CONNECT 0
`define ASI_ST_LINK_ERR 0
`define ASI_ST_PWR_FAIL 1
`define ASI_ST_TIMEOUT 2
`define ASI_ST_EXCHANGE 3
`define ASI_FLAG_COMM_ERR 0
`define ASI_FLAG_PWR_FAIL 1
`define ASI_FLAG_ABSENT 2
`define ASI_INFO_PARAM_LSB 8
`define ASI_PARAM_RST 4'h1
`define ASI_PARAM_MONITOR 0
`define ASI_ADDR_RST 5'h00
// Configuration and identification codes: arbitrary values
`define ASI_IO_CODE 4'h3
`define ASI_ID_CODE 4'h1

// ************************************************
// Timing
// ************************************************
`define ASI_COMM_TMO_MS 70
`define ASI_CLK_KHZ 125000
`define ASI_COMM_TMO_CYC (`ASI_COMM_TMO_MS * `ASI_CLK_KHZ)

`endif

// ===== core/asi_pkg.sv
// Types shared by the slave station modules.
// Assumes asi_regs.svh holds the numeric constants.
package asi_pkg;

   // ************************************************
   // Master request kinds
   // ************************************************
   typedef enum logic [2:0] {
      ASI_CMD_DATA = 3'h0,
      ASI_CMD_PARAM = 3'h1,
      ASI_CMD_ASSIGN = 3'h2,
      ASI_CMD_DELETE = 3'h3,
      ASI_CMD_READ_IO = 3'h4,
      ASI_CMD_READ_ID = 3'h5
   } asi_cmd_type;

   typedef struct packed {
      asi_cmd_type kind;
      logic [4:0] addr;
      logic [4:0] data;
   } asi_req_type;

   typedef struct packed {
      logic valid;
      logic [3:0] data;
   } asi_rsp_type;

endpackage

// ===== core/asi_comm_mon.sv
// Communication monitor: times the gap since the last exchange.
// Assumes activity_i pulses once per exchange addressed to this station.
`timescale 1ns/1ps
`include "asi_regs.svh"
module asi_comm_mon #(
   parameter int unsigned TMO_CYCLES = `ASI_COMM_TMO_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic enable_i,
   input wire logic activity_i,
   output logic timeout_o,
   output logic absent_o
);
   localparam logic [23:0] TMO_LAST = 24'(TMO_CYCLES - 1);
   logic [23:0] gap_reg;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap_reg <= 24'h000000;
      end else if (activity_i) begin
         gap_reg <= 24'h000000;
      end else if (gap_reg != TMO_LAST) begin
         gap_reg <= gap_reg + 24'h000001;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         timeout_o <= 1'b0;
         absent_o <= 1'b0;
      end else begin
         timeout_o <= enable_i && !activity_i && (gap_reg == TMO_LAST - 24'h000001);
         absent_o <= !activity_i && (gap_reg == TMO_LAST - 24'h000001 || absent_o);
      end
   end

   AST_TMO_AFTER_ACT: assert property (@(posedge clk_i) disable iff (rst_i)
      activity_i |=> !timeout_o)
      else $error("timeout right after activity");

endmodule // asi_comm_mon

// ===== core/asi_station.sv
// Station engine: address, parameter bits and point exchange with the master.
// Assumes one decoded request per req_valid_i pulse from the line receiver.
`timescale 1ns/1ps
`include "asi_regs.svh"
module asi_station
   import asi_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic connect_i,
   input wire logic req_valid_i,
   input asi_req_type req_i,
   input wire logic [3:0] out_points_i,
   input wire logic clear_in_i,
   output logic [4:0] addr_o,
   output logic [3:0] param_o,
   output logic [3:0] in_points_o,
   output asi_rsp_type rsp_o,
   output logic exch_o
);
   logic live;
   logic own;
   assign live = req_valid_i && connect_i;
   assign own = live && (req_i.addr == addr_o);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_o <= `ASI_ADDR_RST;
      end else if (own && req_i.kind == ASI_CMD_ASSIGN && addr_o == 5'h00) begin
         if (req_i.data != 5'h00) begin
            addr_o <= req_i.data;
         end
      end else if (own && req_i.kind == ASI_CMD_DELETE) begin
         addr_o <= 5'h00;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         param_o <= `ASI_PARAM_RST;
      end else if (own && req_i.kind == ASI_CMD_PARAM) begin
         param_o <= req_i.data[3:0];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         in_points_o <= 4'h0;
         exch_o <= 1'b0;
      end else begin
         exch_o <= own && req_i.kind == ASI_CMD_DATA && addr_o != 5'h00;
         if (own && req_i.kind == ASI_CMD_DATA && addr_o != 5'h00) begin
            in_points_o <= req_i.data[3:0];
         end else if (clear_in_i) begin
            in_points_o <= 4'h0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rsp_o <= '0;
      end else begin
         rsp_o.valid <= 1'b0;
         rsp_o.data <= 4'h0;
         if (own) begin
            case (req_i.kind)
               ASI_CMD_DATA: begin
                  rsp_o.valid <= (addr_o != 5'h00);
                  rsp_o.data <= out_points_i;
               end
               ASI_CMD_PARAM: begin
                  rsp_o.valid <= 1'b1;
                  rsp_o.data <= req_i.data[3:0];
               end
               ASI_CMD_ASSIGN, ASI_CMD_DELETE: begin
                  rsp_o.valid <= 1'b1;
               end
               ASI_CMD_READ_IO: begin
                  rsp_o.valid <= 1'b1;
                  rsp_o.data <= `ASI_IO_CODE;
               end
               ASI_CMD_READ_ID: begin
                  rsp_o.valid <= 1'b1;
                  rsp_o.data <= `ASI_ID_CODE;
               end
               default: begin
                  rsp_o.valid <= 1'b0;
               end
            endcase
         end
      end
   end

   AST_DISCONNECTED_SILENT: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_valid_i && !connect_i) |=> !rsp_o.valid && $stable(addr_o))
      else $error("station answered while unconnected");

   AST_DELETE_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
      (own && req_i.kind == ASI_CMD_DELETE) |=> addr_o == 5'h00)
      else $error("address not returned to zero");

endmodule // asi_station

// ===== core/asi_slave_io.sv
// Functional notes
// - The station exchanges four input points and four output points with the network.
// - Data bits 0 to 3 of each exchange carry points one to four in both directions.
// - The master assigns the station number, which is zero after reset until set.
// - With monitor parameter bit 0 set, the default, inputs clear after 70 ms without traffic.
// - A network communication error raises the communication error flag toward the host.
// - A network power failure raises a separate power fail flag toward the host.
// - The connect control bit on lets the station take part, off keeps it unconnected.
//
// Top of the slave station: AXI4-Lite register slave, flags and interrupt.
// Assumes a line receiver delivers decoded requests synchronous to clk_i.
`timescale 1ns/1ps
`include "asi_regs.svh"
module asi_slave_io
   import asi_pkg::*;
#(
   parameter int unsigned TMO_CYCLES = `ASI_COMM_TMO_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic req_valid_i,
   input asi_req_type req_i,
   input wire logic link_err_i,
   input wire logic bus_power_ok_i,
   output asi_rsp_type rsp_o,
   output logic irq_o
);

   // ************************************************
   // Declarations
   // ************************************************
   logic [7:0] aw_addr_reg;
   logic [7:0] wr_data_reg;
   logic wr_lane0_reg;
   logic aw_have_reg;
   logic w_have_reg;
   logic network_connect_control_reg;
   logic [3:0] network_output_points_reg;
   logic [3:0] stat_reg;
   logic [3:0] stat_next;
   logic [3:0] mask_reg;
   logic [3:0] mask_next;
   logic comm_error_flag_reg;
   logic bus_power_fail_flag_reg;
   logic pwr_ok_prev_reg;
   logic [3:0] event_set;
   logic wr_fire;
   logic rd_fire;
   logic stat_rd;
   logic [4:0] addr;
   logic [3:0] param;
   logic [3:0] network_input_points;
   logic exch;
   logic timeout;
   logic absent;
   logic [31:0] rd_word;
   logic rd_ok;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, `ASI_OFF_CTRL) || hit(a, `ASI_OFF_IN_POINTS) ||
         hit(a, `ASI_OFF_OUT_POINTS) || hit(a, `ASI_OFF_STATUS) ||
         hit(a, `ASI_OFF_MASK) || hit(a, `ASI_OFF_FLAGS) || hit(a, `ASI_OFF_INFO);
   endfunction

   // ************************************************
   // Station engine and communication monitor
   // ************************************************
   asi_station u_station (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .connect_i(network_connect_control_reg),
      .req_valid_i(req_valid_i),
      .req_i(req_i),
      .out_points_i(network_output_points_reg),
      .clear_in_i(timeout),
      .addr_o(addr),
      .param_o(param),
      .in_points_o(network_input_points),
      .rsp_o(rsp_o),
      .exch_o(exch)
   );

   asi_comm_mon #(
      .TMO_CYCLES(TMO_CYCLES)
   ) u_mon (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .enable_i(param[`ASI_PARAM_MONITOR]),
      .activity_i(exch),
      .timeout_o(timeout),
      .absent_o(absent)
   );

   // ************************************************
   // Write channels
   // ************************************************
   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid_o;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         s_axi_awready_o <= 1'b1;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_have_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr_i;
         s_axi_awready_o <= 1'b0;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
         aw_have_reg <= 1'b0;
         s_axi_awready_o <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         w_have_reg <= 1'b0;
         wr_data_reg <= 8'h00;
         wr_lane0_reg <= 1'b0;
         s_axi_wready_o <= 1'b1;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_have_reg <= 1'b1;
         wr_data_reg <= s_axi_wdata_i[7:0];
         wr_lane0_reg <= s_axi_wstrb_i[0];
         s_axi_wready_o <= 1'b0;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
         w_have_reg <= 1'b0;
         s_axi_wready_o <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= 2'h0;
      end else if (wr_fire) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o <= mapped(aw_addr_reg) ? 2'h0 : 2'h3;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // ************************************************
   // Writable registers
   // ************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         network_connect_control_reg <= 1'b0;
         network_output_points_reg <= 4'h0;
         mask_reg <= 4'h0;
      end else if (wr_fire && wr_lane0_reg) begin
         if (hit(aw_addr_reg, `ASI_OFF_CTRL)) begin
            network_connect_control_reg <= wr_data_reg[`ASI_CTRL_CONNECT];
         end
         if (hit(aw_addr_reg, `ASI_OFF_OUT_POINTS)) begin
            network_output_points_reg <= wr_data_reg[3:0];
         end
         if (hit(aw_addr_reg, `ASI_OFF_MASK)) begin
            mask_reg <= wr_data_reg[3:0];
         end
      end
   end

   // ************************************************
   // Error flags
   // ************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         comm_error_flag_reg <= 1'b0;
         bus_power_fail_flag_reg <= 1'b0;
         pwr_ok_prev_reg <= 1'b1;
      end else begin
         pwr_ok_prev_reg <= bus_power_ok_i;
         bus_power_fail_flag_reg <= !bus_power_ok_i;
         if (link_err_i || !bus_power_ok_i || absent) begin
            comm_error_flag_reg <= 1'b1;
         end else if (exch) begin
            comm_error_flag_reg <= 1'b0;
         end
      end
   end

   // ************************************************
   // Interrupt status, cleared by read
   // ************************************************
   assign event_set[`ASI_ST_LINK_ERR] = link_err_i;
   assign event_set[`ASI_ST_PWR_FAIL] = pwr_ok_prev_reg && !bus_power_ok_i;
   assign event_set[`ASI_ST_TIMEOUT] = timeout;
   assign event_set[`ASI_ST_EXCHANGE] = exch;
   assign stat_rd = rd_fire && hit(s_axi_araddr_i, `ASI_OFF_STATUS);

   always_comb begin
      stat_next = stat_reg;
      if (stat_rd) begin
         stat_next = 4'h0;
      end
      stat_next = stat_next | event_set;
   end

   // Mask as it stands after this edge, so irq follows a mask write at once
   always_comb begin
      mask_next = mask_reg;
      if (wr_fire && wr_lane0_reg && hit(aw_addr_reg, `ASI_OFF_MASK)) begin
         mask_next = wr_data_reg[3:0];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         stat_reg <= 4'h0;
         irq_o <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         irq_o <= |(stat_next & mask_next);
      end
   end

   // ************************************************
   // Read channel
   // ************************************************
   assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;

   always_comb begin
      rd_word = 32'h00000000;
      rd_ok = 1'b1;
      if (hit(s_axi_araddr_i, `ASI_OFF_CTRL)) begin
         rd_word[`ASI_CTRL_CONNECT] = network_connect_control_reg;
      end else if (hit(s_axi_araddr_i, `ASI_OFF_IN_POINTS)) begin
         rd_word[3:0] = network_input_points;
      end else if (hit(s_axi_araddr_i, `ASI_OFF_OUT_POINTS)) begin
         rd_word[3:0] = network_output_points_reg;
      end else if (hit(s_axi_araddr_i, `ASI_OFF_STATUS)) begin
         rd_word[3:0] = stat_reg;
      end else if (hit(s_axi_araddr_i, `ASI_OFF_MASK)) begin
         rd_word[3:0] = mask_reg;
      end else if (hit(s_axi_araddr_i, `ASI_OFF_FLAGS)) begin
         rd_word[`ASI_FLAG_COMM_ERR] = comm_error_flag_reg;
         rd_word[`ASI_FLAG_PWR_FAIL] = bus_power_fail_flag_reg;
         rd_word[`ASI_FLAG_ABSENT] = absent;
      end else if (hit(s_axi_araddr_i, `ASI_OFF_INFO)) begin
         rd_word[4:0] = addr;
         rd_word[`ASI_INFO_PARAM_LSB +: 4] = param;
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h00000000;
         s_axi_rresp_o <= 2'h0;
      end else if (rd_fire) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_word;
         s_axi_rresp_o <= rd_ok ? 2'h0 : 2'h3;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o <= 1'b0;
      end
   end

   // ************************************************
   // Checks
   // ************************************************
   AST_TMO_CLEARS_INPUTS: assert property (@(posedge clk_i) disable iff (rst_i)
      (timeout && !exch) |=> network_input_points == 4'h0)
      else $error("inputs not cleared after timeout");

   AST_MONITOR_OFF_KEEPS: assert property (@(posedge clk_i) disable iff (rst_i)
      (!param[`ASI_PARAM_MONITOR] && !exch) |=> !timeout)
      else $error("timeout with monitor disabled");

   AST_EXCH_POINTS: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_valid_i && network_connect_control_reg && req_i.kind == ASI_CMD_DATA &&
       req_i.addr == addr && addr != 5'h00)
      |=> network_input_points == $past(req_i.data[3:0]) && rsp_o.valid &&
          rsp_o.data == $past(network_output_points_reg))
      else $error("data exchange mismatch");

   AST_ID_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
      (req_valid_i && network_connect_control_reg && req_i.kind == ASI_CMD_READ_ID &&
       req_i.addr == addr) |=> rsp_o.valid && rsp_o.data == `ASI_ID_CODE)
      else $error("wrong identification code");

   AST_ADDR_AT_RESET: assert property (@(posedge clk_i)
      $fell(rst_i) |-> addr == 5'h00)
      else $error("address not zero after reset");

   AST_COMM_ERR_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      link_err_i |=> comm_error_flag_reg ##1 stat_reg[`ASI_ST_LINK_ERR] || $past(stat_rd))
      else $error("communication error flag not raised");

   AST_PWR_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
      (!bus_power_ok_i) |=> bus_power_fail_flag_reg && comm_error_flag_reg)
      else $error("power fail flags not raised");

   AST_PWR_RECOVER: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_power_ok_i [*2] |-> !bus_power_fail_flag_reg)
      else $error("power fail flag stuck");

   AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 irq_o == |(stat_reg & mask_reg))
      else $error("interrupt does not follow status and mask");

   AST_STAT_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
      (stat_rd && timeout) |=> stat_reg[`ASI_ST_TIMEOUT])
      else $error("event lost on status read");

   AST_BVALID_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped");

   AST_WRITE_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
      (aw_have_reg && w_have_reg && !s_axi_bvalid_o) |=> s_axi_bvalid_o)
      else $error("write not answered");

   AST_RVALID_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_axi_rvalid_o && !s_axi_rready_i) |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data changed before taken");

   AST_CONNECT_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_fire && wr_lane0_reg && hit(aw_addr_reg, `ASI_OFF_CTRL))
      |=> network_connect_control_reg == $past(wr_data_reg[`ASI_CTRL_CONNECT]))
      else $error("connect control not stored");

endmodule // asi_slave_io

// ===== tb/asi_master_model.sv
// Network master model: issues decoded requests to one station.
// Assumes the bench calls send from its main sequence.
`timescale 1ns/1ps
module asi_master_model
   import asi_pkg::*;
(
   input wire logic clk_i,
   output logic req_valid_o,
   output asi_req_type req_o
);
   initial begin
      req_valid_o = 1'h0;
      req_o = '0;
   end

   // One station, activated alone, addressed 0..31
   task automatic send(input asi_cmd_type k, input logic [4:0] a, input logic [4:0] d);
      @(posedge clk_i);
      req_valid_o <= 1'h1;
      req_o <= '{kind: k, addr: a, data: d};
      @(posedge clk_i);
      req_valid_o <= 1'h0;
      req_o <= '{kind: ASI_CMD_DATA, addr: ~a, data: ~d};
   endtask
endmodule // asi_master_model

// ===== tb/asi_slave_io_bench.sv
// Bench for the slave station top, with the master model beside it.
// Assumes the design and asi_regs.svh are compiled first.
`timescale 1ns/1ps
`include "asi_regs.svh"
module asi_slave_io_bench
   import asi_pkg::*;
;
   localparam int TMO = 20;
   logic clk_i = 1'h0, rst_i = 1'h1, link_err = 1'h0, pwr_ok = 1'h1;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rnd = 32'h7B83;
   logic awready, wready, bvalid, arready, rvalid, irq, req_valid;
   logic [1:0] bresp, rresp;
   logic [3:0] po = 4'h0;
   asi_req_type req;
   asi_rsp_type rsp;
   int fails = 0, checks = 0, i;
   logic [31:0] expq[$];

   always #4 clk_i = ~clk_i;

   asi_master_model m (.clk_i(clk_i), .req_valid_o(req_valid), .req_o(req));

   asi_slave_io #(.TMO_CYCLES(TMO)) uut (
      .clk_i(clk_i), .rst_i(rst_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .req_valid_i(req_valid),
      .req_i(req), .link_err_i(link_err), .bus_power_ok_i(pwr_ok), .rsp_o(rsp),
      .irq_o(irq)
   );

   // ************************************************
   // Checking
   // ************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic take(input logic [31:0] s);
      logic [31:0] e;
      e = 32'hDEAD_BEEF;
      if (expq.size() != 0) e = expq.pop_front();
      if (e !== '1) chk("result", e, s);
   endtask

   // Oldest note against each response or read word
   always @(posedge clk_i) begin
      if (rsp.valid === 1'h1) take({28'h0, rsp.data});
      if (rvalid === 1'h1 && rready === 1'h1) take(rdata);
   end

   task automatic results;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic lost;
      fails++;
      $display("MISMATCH handshake expected answer seen none");
      results();
   endtask

   // ************************************************
   // Drivers
   // ************************************************
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      bready <= 1'h0;
      if (n == 50) lost();
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      expq.push_back(e);
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      rready <= 1'h0;
      if (n == 50) lost();
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask

   task automatic go(input asi_cmd_type k, input logic [4:0] d, input logic [31:0] e);
      expq.push_back(e);
      m.send(k, 5'h05, d);
   endtask

   task automatic irq_is(input logic v);
      repeat (3) @(negedge clk_i);
      chk("irq", {31'h0, v}, {31'h0, irq});
   endtask

   // ************************************************
   // Sequence
   // ************************************************
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      rd(`ASI_OFF_INFO, 32'h100, 2'h0);
      m.send(ASI_CMD_ASSIGN, 5'h00, 5'h05);
      rd(`ASI_OFF_INFO, 32'h100, 2'h0);
      axw(`ASI_OFF_CTRL, 32'h1, 2'h0);
      expq.push_back(32'h0);
      m.send(ASI_CMD_ASSIGN, 5'h00, 5'h05);
      rd(`ASI_OFF_INFO, 32'h105, 2'h0);
      for (i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         po = rnd[3:0];
         axw(`ASI_OFF_OUT_POINTS, {28'h0, po}, 2'h0);
         go(ASI_CMD_DATA, {1'h0, rnd[7:4]}, {28'h0, po});
         rd(`ASI_OFF_IN_POINTS, {28'h0, rnd[7:4]}, 2'h0);
      end
      go(ASI_CMD_READ_IO, 5'h00, {28'h0, `ASI_IO_CODE});
      go(ASI_CMD_READ_ID, 5'h00, {28'h0, `ASI_ID_CODE});
      go(ASI_CMD_PARAM, 5'h01, 32'h1);
      axw(`ASI_OFF_MASK, 32'h8, 2'h0);
      // Exchanges so far plus the silence timeout that followed reset
      rd(`ASI_OFF_STATUS, 32'hC, 2'h0);
      go(ASI_CMD_DATA, 5'h00, {28'h0, po});
      irq_is(1'h1);
      rd(`ASI_OFF_STATUS, 32'h8, 2'h0);
      irq_is(1'h0);
      axw(`ASI_OFF_MASK, 32'h0, 2'h0);
      go(ASI_CMD_DATA, 5'h00, {28'h0, po});
      irq_is(1'h0);
      go(ASI_CMD_DATA, 5'h00, {28'h0, po});
      link_err <= 1'h1;
      @(posedge clk_i);
      link_err <= 1'h0;
      rd(`ASI_OFF_FLAGS, 32'h1, 2'h0);
      go(ASI_CMD_DATA, 5'h00, {28'h0, po});
      pwr_ok <= 1'h0;
      repeat (2) @(posedge clk_i);
      rd(`ASI_OFF_FLAGS, 32'h3, 2'h0);
      pwr_ok <= 1'h1;
      go(ASI_CMD_DATA, 5'h0F, {28'h0, po});
      repeat (TMO + 5) @(posedge clk_i);
      rd(`ASI_OFF_IN_POINTS, 32'h0, 2'h0);
      rd(`ASI_OFF_FLAGS, 32'h5, 2'h0);
      go(ASI_CMD_PARAM, 5'h00, 32'h0);
      go(ASI_CMD_DATA, 5'h0F, {28'h0, po});
      repeat (TMO + 5) @(posedge clk_i);
      rd(`ASI_OFF_IN_POINTS, 32'hF, 2'h0);
      // Address back to zero before any new network
      go(ASI_CMD_DELETE, 5'h00, 32'h0);
      rd(`ASI_OFF_INFO, 32'h0, 2'h0);
      m.send(ASI_CMD_DATA, 5'h00, 5'h03);
      axw(`ASI_OFF_CTRL, 32'h0, 2'h0);
      m.send(ASI_CMD_ASSIGN, 5'h00, 5'h07);
      rd(`ASI_OFF_INFO, 32'h0, 2'h0);
      rd(8'h1C, 32'h0, 2'h3);
      axw(8'h1C, 32'h1, 2'h3);
      repeat (4) @(posedge clk_i);
      chk("pending", 32'h0, expq.size());
      results();
   end
endmodule // asi_slave_io_bench
